/* src/abx_pkg.sv */
// constants, codes and types shared by the AHB-Lite to AXI bridge
package abx_pkg;
  // ****************************************
  // config register map (APB, byte offsets)
  // ****************************************
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam int RD_OVR_BIT = 0;
  localparam int WR_OVR_BIT = 1;
  localparam int LOCK_OVR_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // ****************************************
  // protocol codes and limits
  // ****************************************
  localparam logic [1:0] HT_SEQ = 2'h3;
  localparam logic [1:0] AX_INCR = 2'h1;
  localparam logic [1:0] AX_WRAP = 2'h2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [2:0] EARLY_MAX = 3'h5;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_DEC = 4'h1,
    S_AR = 4'h2,
    S_RD = 4'h3,
    S_DRAIN = 4'h4,
    S_AW = 4'h5,
    S_W = 4'h6,
    S_B = 4'h7,
    S_WPAD = 4'h8,
    S_ERR1 = 4'h9,
    S_ERR2 = 4'hA
  } abx_state_e;
  // beats of a fixed-length burst, zero for single or undefined length
  function automatic logic [4:0] abx_beats(input logic [2:0] hb);
    case (hb[2:1])
      2'h1: abx_beats = 5'h04;
      2'h2: abx_beats = 5'h08;
      2'h3: abx_beats = 5'h10;
      default: abx_beats = 5'h00;
    endcase
  endfunction
endpackage

/* src/abx_bridge.sv */
// AHB-Lite slave to AXI master bridge with APB configuration port
//
// How it works
// - base config: fixed read bursts stay bursts
// - base config: fixed write burst; only last beat gets response
// - base config: INCR reads become AXI singles
// - INCR writes become singles, each beat answered
// - read override bit forces single reads
// - write override bit forces single writes
// - read/write override bits exist only with EWR or BROKEN_OK
// - cancelled read burst stalls master until drained
// - next unlocked transfer releases held lock
// - swap read error reported on closing write
// - lock override bit suppresses AXI locks
// - secure interface marks every transfer secure
// - non-secure interface marks transfers non-secure
// - address 32-64, data 32-256 bits
// - user sidebands map by access direction
// - little-endian word-invariant byte lanes
// - EWR and broken bursts are build options
// - early response: cacheable (prot[3] set) writes get OKAY
// - at most five early writes outstanding
// - mirrored variant ignores select and ready
module abx_bridge import abx_pkg::*; #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 1,
  parameter bit EARLY_WR = 1'b0,
  parameter bit BROKEN_OK = 1'b0,
  parameter bit LOCK_EN = 1'b1,
  parameter bit SECURE = 1'b1,
  parameter bit MIRRORED = 1'b0
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // AHB-Lite slave side
  input wire logic hsel,
  input wire logic hreadyIn,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic [3:0] hprot,
  input wire logic hmastlock,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic [USER_W-1:0] addrUserSideband,
  input wire logic [USER_W-1:0] writeUserSideband,
  output logic [DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [USER_W-1:0] readUserSideband,
  // AXI write channels
  output logic awvalid,
  input wire logic awready,
  output logic [ADDR_W-1:0] awaddr,
  output logic [7:0] awlen,
  output logic [2:0] awsize,
  output logic [1:0] awburst,
  output logic awlock,
  output logic [2:0] awprot,
  output logic [USER_W-1:0] awuser,
  output logic wvalid,
  input wire logic wready,
  output logic [DATA_W-1:0] wdata,
  output logic [DATA_W/8-1:0] wstrb,
  output logic wlast,
  output logic [USER_W-1:0] wuser,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // AXI read channels
  output logic arvalid,
  input wire logic arready,
  output logic [ADDR_W-1:0] araddr,
  output logic [7:0] arlen,
  output logic [2:0] arsize,
  output logic [1:0] arburst,
  output logic arlock,
  output logic [2:0] arprot,
  output logic [USER_W-1:0] aruser,
  input wire logic rvalid,
  output logic rready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rlast,
  input wire logic [USER_W-1:0] ruser,
  // APB configuration port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************
  // build options and state
  // ****************************************
  localparam int NB = DATA_W / 8;
  localparam int LB = $clog2(NB);
  localparam bit OVR_EN = EARLY_WR || BROKEN_OK;
  localparam bit ABB = BROKEN_OK && !MIRRORED;

  typedef struct packed {
    abx_state_e st;
    logic [ADDR_W-1:0] addr;
    logic [2:0] size;
    logic [2:0] burst;
    logic [3:0] prot;
    logic wr;
    logic seq;
    logic lock;
    logic pend;
    logic early;
    logic [USER_W-1:0] auser;
    logic [USER_W-1:0] wuser;
    logic [USER_W-1:0] ruser;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [4:0] rdLeft;
    logic [4:0] wrLeft;
    logic [7:0] len;
    logic wrap;
    logic [2:0] ewCnt;
    logic swapErr;
    logic lockHeld;
    logic arv;
    logic awv;
    logic wv;
    logic hrdy;
    logic hresp;
    logic [2:0] ctrl;
    logic apbAck;
    logic [31:0] prdata;
    logic slverr;
  } abx_reg_s;

  abx_reg_s r;
  abx_reg_s next_r;
  logic take;
  logic done;
  logic doneErr;
  logic bDrop;
  logic rdOvr;
  logic wrOvr;
  logic lockOvr;
  logic [4:0] nb;
  logic single;

  // byte lanes of a narrow transfer, little-endian within the bus word
  function automatic logic [NB-1:0] abx_strb(input logic [ADDR_W-1:0] a, input logic [2:0] s);
    for (int i = 0; i < NB; i++) begin
      abx_strb[i] = ((i >> s) == (int'(a[LB-1:0]) >> s));
    end
  endfunction

  // ****************************************
  // outputs
  // ****************************************
  // everything seen by either bus comes straight from the state register
  assign hrdata = r.rdata;
  assign hreadyout = r.hrdy;
  assign hresp = r.hresp;
  assign readUserSideband = r.ruser;
  assign awvalid = r.awv;
  assign awaddr = r.addr;
  assign awlen = r.len;
  assign awsize = r.size;
  assign awburst = r.wrap ? AX_WRAP : AX_INCR;
  assign awlock = r.lock && LOCK_EN && !lockOvr;
  assign awprot = {!r.prot[0], !SECURE, r.prot[1]};
  assign awuser = r.auser;
  assign wvalid = r.wv;
  assign wdata = r.wdata;
  assign wstrb = (r.st == S_WPAD) ? '0 : abx_strb(r.addr, r.size);
  assign wlast = (r.wrLeft <= 5'h01);
  assign wuser = r.wuser;
  assign bready = 1'b1;
  assign arvalid = r.arv;
  assign araddr = r.addr;
  assign arlen = r.len;
  assign arsize = r.size;
  assign arburst = r.wrap ? AX_WRAP : AX_INCR;
  assign arlock = r.lock && LOCK_EN && !lockOvr;
  assign arprot = {!r.prot[0], !SECURE, r.prot[1]};
  assign aruser = r.auser;
  assign rready = (r.st == S_RD) || (r.st == S_DRAIN);
  assign prdata = r.prdata;
  assign pready = r.apbAck;
  assign pslverr = r.slverr;

  // override bits are forced off when the build has no use for them
  assign rdOvr = OVR_EN && r.ctrl[RD_OVR_BIT];
  assign wrOvr = OVR_EN && r.ctrl[WR_OVR_BIT];
  assign lockOvr = LOCK_EN && r.ctrl[LOCK_OVR_BIT];
  // mirrored variant has no select or ready input to look at
  assign take = (MIRRORED || (hsel && hreadyIn)) && htrans[1] && r.hrdy;
  assign nb = abx_beats(r.burst);
  // single-beat AXI for undefined length, overrides, or ABB transfers with prot[3] clear
  assign single = (nb == 5'h00) || (r.wr ? wrOvr : rdOvr) || (ABB && !r.prot[3]);
  // responses of early-acked writes arrive first and are swallowed
  assign bDrop = bvalid && (r.ewCnt != 3'h0);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_r = r;
    done = 1'b0;
    doneErr = 1'b0;
    if (bDrop) begin
      next_r.ewCnt = r.ewCnt - 3'h1;
    end
    case (r.st)
      S_IDLE, S_ERR2: begin
        next_r.hresp = 1'b0;
        if (take) begin
          next_r.st = S_DEC;
          next_r.hrdy = 1'b0;
          next_r.addr = haddr;
          next_r.size = hsize;
          next_r.burst = hburst;
          next_r.prot = hprot;
          next_r.wr = hwrite;
          next_r.seq = (htrans == HT_SEQ);
          next_r.lock = hmastlock;
          next_r.auser = addrUserSideband;
        end else begin
          next_r.st = S_IDLE;
          next_r.hrdy = 1'b1;
        end
      end
      S_DEC: begin
        next_r.wdata = hwdata;
        next_r.wuser = writeUserSideband;
        next_r.lockHeld = r.lock;
        next_r.pend = 1'b0;
        if (r.rdLeft != 5'h00 && !(r.seq && !r.wr)) begin
          next_r.st = S_DRAIN;
          next_r.pend = 1'b1;
        end else if (r.wrLeft != 5'h00 && !(r.seq && r.wr)) begin
          next_r.st = S_WPAD; // broken write burst: pad with empty beats
          next_r.wv = 1'b1;
          next_r.pend = 1'b1;
        end else if (r.seq && (r.wr ? r.wrLeft : r.rdLeft) != 5'h00) begin
          next_r.st = r.wr ? S_W : S_RD; // continuing an issued burst
          next_r.wv = r.wr;
        end else begin
          next_r.len = single ? 8'h00 : 8'(nb - 5'h01);
          next_r.wrap = !single && !r.burst[0];
          next_r.early = EARLY_WR && r.prot[3] && !wrOvr;
          next_r.rdLeft = (single || r.wr) ? 5'h00 : nb;
          next_r.wrLeft = (single || !r.wr) ? 5'h00 : nb;
          next_r.st = r.wr ? S_AW : S_AR;
          next_r.awv = r.wr;
          next_r.arv = !r.wr;
        end
      end
      S_AR: begin
        if (arready) begin
          next_r.arv = 1'b0;
          next_r.st = S_RD;
        end
      end
      S_RD: begin
        if (rvalid) begin
          next_r.rdata = rdata;
          next_r.ruser = ruser;
          next_r.rdLeft = (r.rdLeft == 5'h00) ? 5'h00 : r.rdLeft - 5'h01;
          done = 1'b1;
          if (rresp != RESP_OK && r.lock) begin
            next_r.swapErr = 1'b1; // held back until the swap write
          end else begin
            doneErr = (rresp != RESP_OK);
          end
        end
      end
      S_DRAIN: begin
        // master stays stalled while the abandoned beats are consumed
        if (rvalid && rlast) begin
          next_r.rdLeft = 5'h00;
          next_r.st = r.pend ? S_DEC : S_IDLE;
          next_r.hrdy = !r.pend;
        end
      end
      S_AW: begin
        if (awready) begin
          next_r.awv = 1'b0;
          next_r.wv = 1'b1;
          next_r.st = S_W;
        end
      end
      S_W: begin
        if (wready) begin
          next_r.wv = 1'b0;
          next_r.wrLeft = (r.wrLeft == 5'h00) ? 5'h00 : r.wrLeft - 5'h01;
          if (r.wrLeft > 5'h01) begin
            done = 1'b1; // any beat of a burst but the last
          end else begin
            next_r.st = S_B;
          end
        end
      end
      S_B: begin
        if (r.early) begin
          // sixth early write waits for a slot before it is acked
          if (next_r.ewCnt < EARLY_MAX) begin
            next_r.ewCnt = next_r.ewCnt + 3'h1;
            doneErr = r.swapErr;
            next_r.swapErr = 1'b0;
            done = 1'b1;
          end
        end else if (bvalid && !bDrop) begin
          done = 1'b1;
          doneErr = (bresp != RESP_OK) || r.swapErr;
          next_r.swapErr = 1'b0;
        end
      end
      S_WPAD: begin
        if (wready) begin
          next_r.wrLeft = r.wrLeft - 5'h01;
          if (r.wrLeft == 5'h01) begin
            next_r.wv = 1'b0;
            next_r.ewCnt = next_r.ewCnt + 3'h1; // its response is discarded
            next_r.st = S_DEC;
          end
        end
      end
      S_ERR1: begin
        next_r.st = S_ERR2;
        next_r.hrdy = 1'b1;
      end
      default: begin
        next_r.st = S_IDLE;
        next_r.hrdy = 1'b1;
      end
    endcase
    // two-cycle AHB error, or a plain one-cycle OKAY
    if (done) begin
      next_r.st = doneErr ? S_ERR1 : S_IDLE;
      next_r.hrdy = !doneErr;
      next_r.hresp = doneErr;
    end
    // APB: one wait state so read data comes from a flop
    next_r.apbAck = 1'b0;
    if (psel && penable && !r.apbAck) begin
      next_r.apbAck = 1'b1;
      next_r.slverr = (paddr != CTRL_OFF) && (paddr != STATUS_OFF);
      next_r.prdata = 32'h0;
      if (paddr == CTRL_OFF) begin
        next_r.prdata[2:0] = r.ctrl;
      end else if (paddr == STATUS_OFF) begin
        next_r.prdata[22:2] = {r.st, r.ewCnt, r.swapErr, r.lockHeld, r.rdLeft, r.wrLeft, r.hrdy, r.hresp};
      end
    end
    // the write lands at the edge where the master sees pready high, not before
    if (psel && penable && pwrite && r.apbAck && (paddr == CTRL_OFF)) begin
      next_r.ctrl = pwdata[2:0] & {LOCK_EN, OVR_EN, OVR_EN};
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= S_IDLE;
      r.hrdy <= 1'b1;
      r.ctrl <= CTRL_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  a_ar_hold: assert property (arvalid && !arready |=> arvalid && $stable(araddr) && $stable(arlen))
    else $error("read address dropped before handshake");
  a_rd_override: assert property (arvalid |-> !rdOvr || arlen == 8'h00)
    else $error("read override ignored");
  a_wr_override: assert property (awvalid |-> !wrOvr || awlen == 8'h00)
    else $error("write override ignored");
  a_incr_single: assert property (arvalid && r.burst == 3'h1 |-> arlen == 8'h00)
    else $error("undefined-length read issued as burst");
  a_prot_flag: assert property (arvalid || awvalid |-> arprot[1] == !SECURE && awprot[1] == !SECURE)
    else $error("security flag wrong");
  a_lock_off: assert property (arvalid && lockOvr |-> !arlock)
    else $error("lock issued while suppressed");
  a_early_cap: assert property (r.ewCnt <= EARLY_MAX)
    else $error("too many early writes outstanding");
  a_drain_stall: assert property (r.st == S_DRAIN |-> !hreadyout ##1 (r.st == S_DRAIN || !hreadyout || !r.pend))
    else $error("master released during drain");
  a_err_pair: assert property (r.st == S_ERR1 |-> hresp && !hreadyout ##1 hresp && hreadyout)
    else $error("malformed two-cycle error");
  a_burst_last: assert property (r.st == S_B && !r.early && bvalid && !bDrop && bresp != RESP_OK |=> hresp)
    else $error("write error not returned");

  c_read_burst: cover property (arvalid && arready && arlen != 8'h00);
  c_write_burst: cover property (wvalid && wready && wlast && awlen != 8'h00);
  c_drain: cover property (r.st == S_DRAIN ##1 r.st == S_DEC);
endmodule // abx_bridge

/* verif/abx_axi_model.sv */
// behavioural AXI slave standing where the interconnect meets the bridge
module abx_axi_model import abx_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // scenario controls
  input wire logic slow,
  input wire logic errRd,
  input wire logic errWr,
  // write side
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [7:0] awlen,
  input wire logic awlock,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wlast,
  input wire logic [0:0] wuser,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read side
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [7:0] arlen,
  input wire logic [1:0] arburst,
  input wire logic arlock,
  input wire logic [2:0] arprot,
  input wire logic [0:0] aruser,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rlast,
  output logic [0:0] ruser
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase, rGo, rE, arK, awK, arU, wU;
  logic [8:0] rLeft;
  logic [15:0] rA;
  logic [7:0] arL, awL;
  logic [2:0] arP;
  logic [31:0] wD;
  logic [31:0] awA;
  logic [3:0] wS;
  logic [1:0] arB;
  int arN = 0;
  int awN = 0;
  int wN = 0;
  int rN = 0;
  // slow mode offers ready every other cycle only; ready may drop freely
  assign awready = !slow | phase;
  assign wready = !slow | phase;
  assign arready = (rLeft == 9'h000) & (!slow | phase);
  // rGo keeps valid up until its handshake, so payload never moves early
  assign rvalid = (rLeft != 9'h000) & rGo;
  assign rdata = rvalid ? {rA, 16'hC3C3} : {~rA, 16'h3C3C};
  assign ruser = rvalid ? rA[2] : ~rA[2];
  assign rlast = rLeft == 9'h001;
  assign rresp = rE ? 2'h2 : RESP_OK;
  // one transfer per direction in flight, which is all the bridge issues
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      rGo <= 1'b0;
      rLeft <= 9'h000;
      bvalid <= 1'b0;
    end else begin
      phase <= !phase;
      rGo <= (rGo & !(rvalid & rready)) | !slow | phase;
      if (arvalid & arready) begin
        arN <= arN + 1;
        arL <= arlen;
        arK <= arlock;
        arP <= arprot;
        arU <= aruser[0];
        arB <= arburst;
        rE <= errRd;
        rLeft <= {1'b0, arlen} + 9'h001;
        rA <= araddr[15:0];
      end else if (rvalid & rready) begin
        rN <= rN + 1;
        rLeft <= rLeft - 9'h001;
        rA <= rA + 16'h0004;
      end
      if (awvalid & awready) begin
        awN <= awN + 1;
        awL <= awlen;
        awK <= awlock;
        awA <= awaddr;
      end
      if (wvalid & wready) begin
        wN <= wN + 1;
        wD <= wdata;
        wU <= wuser[0];
        wS <= wstrb;
      end
      if (wvalid & wready & wlast) begin
        bresp <= errWr ? 2'h2 : RESP_OK;
      end
      bvalid <= (wvalid & wready & wlast) | (bvalid & !bready);
    end
  end
endmodule // abx_axi_model

/* verif/abx_bridge_tb.sv */
// self-checking bench for the bridge in its base build
module abx_bridge_tb import abx_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // signals
  // ********
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hsel = 1'b1, hreadyIn = 1'b1, hwrite = 1'b0, hmastlock = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, hburst = 3'h0;
  logic [3:0] hprot = 4'h3;
  logic [0:0] addrUserSideband = 1'h0, writeUserSideband = 1'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, errRd = 1'b0, errWr = 1'b0, lk = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] hrdata, awaddr, araddr, wdata, rdata, prdata, q;
  logic hreadyout, hresp, awvalid, awready, awlock, wvalid, wready, wlast, bvalid, bready, e;
  logic arvalid, arready, arlock, rvalid, rready, rlast, pready, pslverr;
  logic [7:0] awlen, arlen;
  logic [2:0] awsize, arsize, awprot, arprot;
  logic [1:0] awburst, arburst, bresp, rresp;
  logic [3:0] wstrb;
  logic [0:0] readUserSideband, awuser, aruser, wuser, ruser;
  logic [31:0] rd [16];
  logic rs [16];
  logic ru [16];
  int cyc = 0;
  int nChecks = 0;
  int miscompares = 0;
  int b0, b1;
  abx_bridge u_abx_bridge (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .hreadyIn(hreadyIn), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hprot(hprot), .hmastlock(hmastlock), .hwdata(hwdata),
    .addrUserSideband(addrUserSideband), .writeUserSideband(writeUserSideband), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .readUserSideband(readUserSideband),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awlen(awlen), .awsize(awsize), .awburst(awburst),
    .awlock(awlock), .awprot(awprot), .awuser(awuser), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .wlast(wlast), .wuser(wuser), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arlen(arlen), .arsize(arsize), .arburst(arburst),
    .arlock(arlock), .arprot(arprot), .aruser(aruser), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .rlast(rlast), .ruser(ruser), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  abx_axi_model u_abx_axi_model (
    .clk(clk), .rst_n(rst_n), .slow(slow), .errRd(errRd), .errWr(errWr),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awlen(awlen), .awlock(awlock),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wuser(wuser),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arlen(arlen), .arburst(arburst), .arlock(arlock),
    .arprot(arprot), .aruser(aruser), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .rlast(rlast), .ruser(ruser)
  );
  initial forever #10 clk = ~clk;
  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] pat(input logic [31:0] x);
    return {x[15:0], 16'hC3C3};
  endfunction
  task automatic closeOut();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // n beats of one burst; the address of a beat overlaps the data of the one before
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] hb, input int n);
    for (int i = 0; i <= n; i++) begin
      htrans <= (i == n) ? 2'h0 : ((i == 0) ? 2'h2 : HT_SEQ);
      haddr <= a + 32'(4 * i);
      hwrite <= wr;
      hburst <= hb;
      hmastlock <= lk & (i < n);
      addrUserSideband <= a[4];
      if (i > 0) begin
        hwdata <= {16'h5AA5, a[15:0] + 16'(4 * i - 4)};
        writeUserSideband <= ~a[4];
      end
      do @(posedge clk); while (hreadyout !== 1'b1);
      if (i > 0) begin
        rd[i - 1] = hrdata;
        rs[i - 1] = hresp;
        ru[i - 1] = readUserSideband[0];
      end
    end
  endtask
  // watchdog: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      closeOut();
    end
  end
  // ********
  // tests
  // ********
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("hreadyout", 32'(hreadyout), 32'h1);
    // the override bits must not stick in the base build; lock override does
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl reset", q, {29'h0, CTRL_RST});
    // idle status: only the ready flag is up, at bit 3
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("status idle", q, 32'h8);
    apb(1'b1, CTRL_OFF, 32'h7);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl bits", q, 32'h4);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 32'(e), 32'h1);
    apb(1'b1, CTRL_OFF, 32'h0);
    // fixed read bursts, wrapping and incrementing, stay one burst
    for (int k = 0; k < 2; k++) begin
      b0 = u_abx_axi_model.arN;
      ahb(1'b0, 32'h110, 3'h2 + 3'(k), 4);
      chk("ar count", 32'(u_abx_axi_model.arN - b0), 32'h1);
      chk("ar len", 32'(u_abx_axi_model.arL), 32'h3);
      chk("ar burst", 32'(u_abx_axi_model.arB), (k == 0) ? 32'(AX_WRAP) : 32'(AX_INCR));
      chk("ar prot", 32'(u_abx_axi_model.arP), 32'h1);
      chk("ar user", 32'(u_abx_axi_model.arU), 32'h1);
      chk("rd user", 32'(ru[3]), 32'h1);
      for (int j = 0; j < 4; j++) chk("rd data", rd[j], pat(32'h110 + 32'(4 * j)));
    end
    // fixed write burst with a failing response: only its last beat reports it
    errWr <= 1'b1;
    b0 = u_abx_axi_model.awN;
    b1 = u_abx_axi_model.wN;
    ahb(1'b1, 32'h200, 3'h3, 4);
    chk("aw count", 32'(u_abx_axi_model.awN - b0), 32'h1);
    chk("aw len", 32'(u_abx_axi_model.awL), 32'h3);
    chk("w count", 32'(u_abx_axi_model.wN - b1), 32'h4);
    chk("w data", u_abx_axi_model.wD, 32'h5AA5020C);
    chk("w user", 32'(u_abx_axi_model.wU), 32'h1);
    chk("aw addr", u_abx_axi_model.awA, 32'h200);
    chk("w strb", 32'(u_abx_axi_model.wS), 32'hF);
    for (int j = 0; j < 4; j++) chk("wr resp", 32'(rs[j]), 32'(j == 3));
    // undefined-length write: singles, every beat carries its own response
    b0 = u_abx_axi_model.awN;
    ahb(1'b1, 32'h300, 3'h1, 2);
    errWr <= 1'b0;
    chk("aw singles", 32'(u_abx_axi_model.awN - b0), 32'h2);
    chk("aw len", 32'(u_abx_axi_model.awL), 32'h0);
    chk("wr resp", 32'(rs[0] & rs[1]), 32'h1);
    // undefined-length read against a stalling slave: singles
    slow <= 1'b1;
    b0 = u_abx_axi_model.arN;
    ahb(1'b0, 32'h400, 3'h1, 3);
    chk("ar singles", 32'(u_abx_axi_model.arN - b0), 32'h3);
    chk("ar len", 32'(u_abx_axi_model.arL), 32'h0);
    chk("rd data", rd[2], pat(32'h408));
    // error on the first beat and the master walks away: the rest must drain first
    errRd <= 1'b1;
    b0 = u_abx_axi_model.rN;
    ahb(1'b0, 32'h500, 3'h3, 1);
    errRd <= 1'b0;
    chk("err resp", 32'(rs[0]), 32'h1);
    ahb(1'b0, 32'h600, 3'h0, 1);
    chk("drained", 32'(u_abx_axi_model.rN - b0), 32'h5);
    chk("rd data", rd[0], pat(32'h600));
    slow <= 1'b0;
    // swap pairs: read error held back to the closing write; then lock override on
    for (int k = 0; k < 2; k++) begin
      lk = 1'b1;
      errRd <= (k == 0);
      ahb(1'b0, 32'h700, 3'h0, 1);
      chk("swap rd resp", 32'(rs[0]), 32'h0);
      errRd <= 1'b0;
      repeat (3) @(posedge clk);
      ahb(1'b1, 32'h700, 3'h0, 1);
      lk = 1'b0;
      chk("swap wr resp", 32'(rs[0]), 32'(k == 0));
      chk("ar lock", 32'(u_abx_axi_model.arK), 32'(k == 0));
      chk("aw lock", 32'(u_abx_axi_model.awK), 32'(k == 0));
      apb(1'b1, CTRL_OFF, 32'h4);
    end
    closeOut();
  end
endmodule // abx_bridge_tb
